// ===== verilog/svm_top.sv
`include "svm_consts.svh"
`default_nettype none
module svm_top
(
   input wire logic clock,
   input wire logic resetn,
   input wire svm_pkg::svm_addr_t mem_addr,
   input wire svm_pkg::svm_byte_t mem_wdata,
   input wire logic mem_write,
   input wire logic mem_read,
   output svm_pkg::svm_byte_t mem_rdata,
   input wire logic power_on_comparator_below,
   input wire logic voltage_monitor_below,
   output logic comparator_enable,
   output svm_pkg::svm_code_t threshold_code,
   output logic monitor_irq,
   output logic internal_reset
);
   import svm_pkg::*;

   svm_cmp_if cmp ();

   logic monitor_enable;
   logic monitor_mode_select;
   logic monitor_irq_mask;
   logic monitor_irq_request_flag;
   logic low_voltage_reset_cause;
   logic irq_level_q;
   logic low_supply_flag;
   logic monitor_reset_req;
   logic next_internal_reset;
   logic next_monitor_irq;
   logic wr_control;
   logic wr_level;
   logic wr_irq;
   logic rd_cause;
   logic hit_control;
   logic hit_level;
   logic hit_irq;
   logic hit_cause;
   svm_byte_t next_rdata;

   assign cmp.poc_below_raw = power_on_comparator_below;
   assign cmp.lvi_below_raw = voltage_monitor_below;

   svm_sync3 u_sync
   (
      .clock(clock),
      .resetn(resetn),
      .cmp(cmp)
   );

   // Decoded once, shared by the write strobes and the read mux
   always_comb
   begin
      hit_control = 1'b0;
      hit_level = 1'b0;
      hit_irq = 1'b0;
      hit_cause = 1'b0;
      if (mem_addr == `SVM_ADDR_CONTROL)
         hit_control = 1'b1;
      else if (mem_addr == `SVM_ADDR_LEVEL)
         hit_level = 1'b1;
      else if (mem_addr == `SVM_ADDR_IRQ)
         hit_irq = 1'b1;
      else if (mem_addr == `SVM_ADDR_CAUSE)
         hit_cause = 1'b1;
   end

   assign wr_control = mem_write & hit_control;
   assign wr_level = mem_write & hit_level;
   assign wr_irq = mem_write & hit_irq;
   assign rd_cause = mem_read & hit_cause;

   assign low_supply_flag = monitor_enable & cmp.lvi_below;
   // Reset mode only trips while the comparator says low, so arming it is safe
   assign monitor_reset_req = low_supply_flag & monitor_mode_select;
   assign next_internal_reset = cmp.poc_below | monitor_reset_req;
   assign next_monitor_irq = low_supply_flag & ~monitor_mode_select;

   // Control and level registers; power-on reset clears, monitor reset does not
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         monitor_enable <= 1'(`SVM_CONTROL_RESET >> `SVM_CTL_ENABLE_BIT);
         monitor_mode_select <= 1'b0;
         threshold_code <= 4'(`SVM_LEVEL_RESET);
      end
      else if (cmp.poc_below)
      begin
         monitor_enable <= 1'b0;
         monitor_mode_select <= 1'b0;
         threshold_code <= 4'h0;
      end
      else
      begin
         if (wr_control)
         begin
            // Flag bit 0 and bits 2 to 6 are not stored
            monitor_enable <= mem_wdata[`SVM_CTL_ENABLE_BIT];
            monitor_mode_select <= mem_wdata[`SVM_CTL_MODE_BIT];
         end
         // Prohibited codes pass through unchanged; the analog side copes
         if (wr_level)
            threshold_code <= mem_wdata[3:0];
      end
   end

   assign comparator_enable = monitor_enable;

   // Any reset leaves the source masked
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         monitor_irq_mask <= 1'b1;
      else if (next_internal_reset)
         monitor_irq_mask <= 1'b1;
      else if (wr_irq)
         monitor_irq_mask <= mem_wdata[`SVM_IRQ_MASK_BIT];
   end

   // Rising edge sets; set beats a simultaneous software clear
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         monitor_irq_request_flag <= 1'b0;
         irq_level_q <= 1'b0;
      end
      else
      begin
         irq_level_q <= next_monitor_irq;
         if (next_monitor_irq && !irq_level_q)
            monitor_irq_request_flag <= 1'b1;
         else if (wr_irq)
            monitor_irq_request_flag <= mem_wdata[`SVM_IRQ_REQ_BIT];
      end
   end

   // Cause bit: set by monitor reset, cleared by power-on reset or a read
   // Set beats the read-clear, so a read racing a trip cannot lose the cause
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         low_voltage_reset_cause <= 1'b0;
      else if (cmp.poc_below)
         low_voltage_reset_cause <= 1'b0;
      else if (monitor_reset_req)
         low_voltage_reset_cause <= 1'b1;
      else if (rd_cause)
         low_voltage_reset_cause <= 1'b0;
   end

   // Core stays in reset until the first edge after release
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         internal_reset <= 1'b1;
      else
         internal_reset <= next_internal_reset;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         monitor_irq <= 1'b0;
      else
         monitor_irq <= next_monitor_irq;
   end

   always_comb
   begin
      next_rdata = 8'h00;
      // Unmapped addresses and unused bits read as zero
      if (hit_control)
      begin
         next_rdata[`SVM_CTL_ENABLE_BIT] = monitor_enable;
         next_rdata[`SVM_CTL_MODE_BIT] = monitor_mode_select;
         next_rdata[`SVM_CTL_FLAG_BIT] = low_supply_flag;
      end
      else if (hit_level)
         next_rdata[3:0] = threshold_code;
      else if (hit_irq)
      begin
         next_rdata[`SVM_IRQ_MASK_BIT] = monitor_irq_mask;
         next_rdata[`SVM_IRQ_REQ_BIT] = monitor_irq_request_flag;
      end
      else if (hit_cause)
         next_rdata[`SVM_CAUSE_LV_BIT] = low_voltage_reset_cause;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         mem_rdata <= 8'h00;
      else if (mem_read)
         mem_rdata <= next_rdata;
   end
endmodule
`default_nettype wire

// ===== verilog/svm_consts.svh
`ifndef SVM_CONSTS_SVH
`define SVM_CONSTS_SVH

`define SVM_ADDR_CONTROL 16'hff50
`define SVM_ADDR_LEVEL 16'hff51
`define SVM_ADDR_IRQ 16'hff52
`define SVM_ADDR_CAUSE 16'hff54

`define SVM_CTL_ENABLE_BIT 7
`define SVM_CTL_MODE_BIT 1
`define SVM_CTL_FLAG_BIT 0
`define SVM_IRQ_REQ_BIT 0
`define SVM_IRQ_MASK_BIT 1
`define SVM_CAUSE_LV_BIT 0

`define SVM_CONTROL_RESET 8'h00
`define SVM_LEVEL_RESET 8'h00
`define SVM_CAUSE_RESET 8'h00
`define SVM_CODE_LAST 4'h9

`define SVM_SETTLE_NS 200000
`define SVM_CLOCK_NS 100
`define SVM_SETTLE_CYCLES ((`SVM_SETTLE_NS + `SVM_CLOCK_NS - 1) / `SVM_CLOCK_NS)

`endif

// ===== verilog/svm_pkg.sv
`default_nettype none
package svm_pkg;
   typedef logic [7:0] svm_byte_t;
   typedef logic [15:0] svm_addr_t;
   typedef logic [3:0] svm_code_t;
endpackage
`default_nettype wire

// ===== verilog/svm_cmp_if.sv
`default_nettype none
interface svm_cmp_if;
   logic poc_below_raw;
   logic lvi_below_raw;
   logic poc_below;
   logic lvi_below;
   modport sync (input poc_below_raw, input lvi_below_raw, output poc_below, output lvi_below);
   modport user (output poc_below_raw, output lvi_below_raw, input poc_below, input lvi_below);
endinterface
`default_nettype wire

// ===== verilog/svm_sync3.sv
`default_nettype none
module svm_sync3
(
   input wire logic clock,
   input wire logic resetn,
   svm_cmp_if.sync cmp
);
   import svm_pkg::*;

   logic [2:0] poc_pipe;
   logic [2:0] lvi_pipe;
   logic poc_state;
   logic lvi_state;

   // Stage 0 feeds only stage 1; the agreement test looks at stages 1 and 2
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         poc_pipe <= 3'h0;
         lvi_pipe <= 3'h0;
      end
      else
      begin
         poc_pipe <= {poc_pipe[1:0], cmp.poc_below_raw};
         lvi_pipe <= {lvi_pipe[1:0], cmp.lvi_below_raw};
      end
   end

   // Filter out single-cycle glitches near the trip point
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         poc_state <= 1'b0;
         lvi_state <= 1'b0;
      end
      else
      begin
         if (poc_pipe[1] == poc_pipe[2])
            poc_state <= poc_pipe[2];
         if (lvi_pipe[1] == lvi_pipe[2])
            lvi_state <= lvi_pipe[2];
      end
   end

   assign cmp.poc_below = poc_state;
   assign cmp.lvi_below = lvi_state;
endmodule
`default_nettype wire

// ===== verification/svm_properties.sv
`default_nettype none
module svm_properties
(
   input wire logic clock,
   input wire logic resetn,
   input wire svm_pkg::svm_addr_t mem_addr,
   input wire svm_pkg::svm_byte_t mem_wdata,
   input wire logic mem_write,
   input wire logic mem_read,
   input wire svm_pkg::svm_byte_t mem_rdata,
   input wire logic power_on_comparator_below,
   input wire logic voltage_monitor_below,
   input wire logic comparator_enable,
   input wire svm_pkg::svm_code_t threshold_code,
   input wire logic monitor_irq,
   input wire logic internal_reset
);
   import svm_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Power-on reset clears the registers; its pin reaches them four edges late
   enable_write_a:
   assert property (!power_on_comparator_below [*5] ##0 (mem_write && mem_addr == 16'hff50)
      |=> comparator_enable == $past(mem_wdata[7])) else $error("enable bit not stored");
   code_write_a:
   assert property (!power_on_comparator_below [*5] ##0 (mem_write && mem_addr == 16'hff51)
      |=> threshold_code == $past(mem_wdata[3:0])) else $error("threshold code not stored");
   ctl_read_a:
   assert property (mem_read && mem_addr == 16'hff50
      |=> mem_rdata[7:2] == {$past(comparator_enable), 5'h00}) else $error("control read bad");
   level_read_a:
   assert property (mem_read && mem_addr == 16'hff51
      |=> mem_rdata == {4'h0, $past(threshold_code)}) else $error("level read bad");
   irq_disabled_a:
   assert property (!comparator_enable [*2] |-> !monitor_irq) else $error("irq while disabled");
   irq_cause_a:
   assert property (!voltage_monitor_below [*8] |-> !monitor_irq) else $error("irq, supply good");
   poc_hold_a:
   assert property (power_on_comparator_below [*6] |-> internal_reset) else $error("no poc reset");
   supply_good_a:
   assert property ((!power_on_comparator_below && !voltage_monitor_below) [*8]
      |-> !internal_reset) else $error("reset with supply good");
   mode_excl_a:
   assert property (!power_on_comparator_below [*6] |-> !(monitor_irq && internal_reset))
      else $error("irq and reset together");
   cover property (monitor_irq);
   cover property (internal_reset && !power_on_comparator_below);
   cover property (mem_read && mem_addr == 16'hff54);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`include "svm_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import svm_pkg::*;
   logic clock = 0, resetn = 0, mem_write = 0, mem_read = 0, rd_seen = 0;
   logic power_on_comparator_below = 0, voltage_monitor_below = 0;
   logic comparator_enable, monitor_irq, internal_reset;
   svm_addr_t mem_addr = 16'h0000;
   svm_byte_t mem_wdata = 8'h00, mem_rdata;
   svm_code_t threshold_code, code;
   svm_byte_t expq[$];
   int err_total = 0, n_checks = 0;
   svm_top uut (.clock, .resetn, .mem_addr, .mem_wdata, .mem_write, .mem_read, .mem_rdata,
      .power_on_comparator_below, .voltage_monitor_below, .comparator_enable,
      .threshold_code, .monitor_irq, .internal_reset);
   initial
   forever #50 clock = ~clock;
   task check(input string what, input svm_byte_t seen, input svm_byte_t exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wr(input svm_addr_t a, input svm_byte_t d);
      cyc(1);
      mem_addr = a;
      mem_wdata = d;
      mem_write = 1;
      cyc(1);
      mem_write = 0;
   endtask
   // Expected value queued here, compared by the watcher below
   task rd(input svm_addr_t a, input svm_byte_t exp);
      cyc(1);
      mem_addr = a;
      mem_read = 1;
      expq.push_back(exp);
      cyc(1);
      mem_read = 0;
   endtask
   task await(input bit irq, input logic val, input string what);
      int i;
      for (i = 0; i < 40 && (irq ? monitor_irq : internal_reset) !== val; i++)
         cyc(1);
      check(what, irq ? monitor_irq : internal_reset, val);
      if (i == 40)
         finish_test;
   endtask
   always @(posedge clock) rd_seen <= mem_read;
   always @(negedge clock)
      if (rd_seen)
         check("mem_rdata", mem_rdata, expq.pop_front());
   initial
   begin
      void'($urandom(32'h56f42237));
      cyc(4);
      resetn = 1;
      rd(16'hff50, 8'h00);
      rd(16'hff51, 8'h00);
      rd(16'hff52, 8'h02);
      rd(16'hff54, 8'h00);
      wr(16'hff53, 8'($urandom));
      rd(16'hff53, 8'h00);
      $display("test reset values done");
      for (int c = 0; c < 10; c++)
      begin
         wr(16'hff51, {4'h0, c[3:0]});
         rd(16'hff51, {4'h0, c[3:0]});
         check("threshold_code", threshold_code, c[3:0]);
      end
      code = 4'($urandom_range(9));
      wr(16'hff51, {4'h0, code});
      rd(16'hff51, {4'h0, code});
      $display("test threshold codes done");
      wr(16'hff50, 8'h81);
      check("comparator_enable", comparator_enable, 1'b1);
      cyc(`SVM_SETTLE_CYCLES);
      rd(16'hff50, 8'h80);
      wr(16'hff50, 8'h83);
      rd(16'hff50, 8'h82);
      cyc(10);
      check("internal_reset", internal_reset, 1'b0);
      $display("test control bits done");
      voltage_monitor_below = 1;
      await(0, 1, "internal_reset");
      rd(16'hff50, 8'h83);
      rd(16'hff54, 8'h01);
      voltage_monitor_below = 0;
      await(0, 0, "internal_reset");
      // Reads during the reset lose to the set, so the cause is still there
      rd(16'hff54, 8'h01);
      rd(16'hff54, 8'h00);
      rd(16'hff52, 8'h02);
      rd(16'hff50, 8'h82);
      wr(16'hff50, 8'h80);
      wr(16'hff50, 8'h00);
      rd(16'hff50, 8'h00);
      $display("test reset mode done");
      wr(16'hff50, 8'h80);
      cyc(`SVM_SETTLE_CYCLES);
      rd(16'hff50, 8'h80);
      wr(16'hff52, 8'h02);
      wr(16'hff52, 8'h00);
      voltage_monitor_below = 1;
      await(1, 1, "monitor_irq");
      rd(16'hff50, 8'h81);
      rd(16'hff52, 8'h01);
      voltage_monitor_below = 0;
      await(1, 0, "monitor_irq");
      wr(16'hff52, 8'h00);
      wr(16'hff50, 8'h00);
      voltage_monitor_below = 1;
      cyc(10);
      check("monitor_irq", monitor_irq, 1'b0);
      rd(16'hff50, 8'h00);
      voltage_monitor_below = 0;
      $display("test interrupt mode done");
      power_on_comparator_below = 1;
      await(0, 1, "internal_reset");
      power_on_comparator_below = 0;
      await(0, 0, "internal_reset");
      rd(16'hff50, 8'h00);
      rd(16'hff51, 8'h00);
      $display("test power-on reset done");
      cyc(2);
      finish_test;
   end
endmodule
bind svm_top svm_properties chk (.clock, .resetn, .mem_addr, .mem_wdata, .mem_write,
   .mem_read, .mem_rdata, .power_on_comparator_below, .voltage_monitor_below,
   .comparator_enable, .threshold_code, .monitor_irq, .internal_reset);
`default_nettype wire
